// ===== core/fsh_host.sv
/*
 * serial flash host controller: software orders frames over AXI4-Lite,
 * the controller drives chip enable, the link clock and four data lanes.
 * assumes flash lane inputs are asynchronous; AXI is on clk.
 */
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module fsh_host
	import fsh_pkg::*;
#(
	parameter int SUSP_GAP = SUSP_GAP_CYC,
	parameter int SCK_HALF = SCK_HALF_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// flash link
	output logic flash_ce_n,
	output logic flash_sck,
	output logic [3:0] flash_io_o,
	output logic [3:0] flash_io_oe,
	input wire logic [3:0] flash_io_i
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		fsh_st_t st;
		logic [7:0] op;
		logic [23:0] adr;
		logic cfg_quad;
		logic [8:0] nbuf;
		logic [8:0] nb;
		logic [7:0] div;
		logic sck;
		logic ce_n;
		logic [3:0] oe;
		logic [3:0] io;
		logic [31:0] sh;
		logic [5:0] cnt;
		logic q;
		logic [31:0] rd;
		logic done;
		logic err;
		logic susp;
		logic [TMR_W-1:0] tmr;
		logic awr;
		logic wr;
		logic aw_h;
		logic w_h;
		logic [7:0] awa;
		logic [31:0] wd;
		logic bv;
		logic [1:0] br;
		logic arr;
		logic rv;
		logic [31:0] rdat;
		logic [1:0] rr;
	} fsh_state_t;

	fsh_state_t s_r;
	fsh_state_t n;
	logic ld;
	logic mwe;
	logic [3:0] in_s;
	logic [7:0] buf_rd;
	logic [7:0] op_w;

	fsh_sync #(.W(4)) u_sync (
		.clk(clk),
		.rst(rst),
		.d(flash_io_i),
		.q(in_s)
	);

	fsh_pbuf #(.DW(8), .DEPTH(PAGE_BYTES), .AW(8)) u_pbuf (
		.clk(clk),
		.we(mwe),
		.waddr(s_r.nbuf[7:0]),
		.wdata(s_r.wd[7:0]),
		.raddr(s_r.nb[7:0]),
		.rdata(buf_rd)
	);

	function automatic logic is_wr(input logic [7:0] op);
		return op == OP_SE || op == OP_BE || op == OP_CE || op == OP_PP || op == OP_QPP;
	endfunction

	function automatic logic is_prog(input logic [7:0] op);
		return op == OP_PP || op == OP_QPP;
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	assign op_w = s_r.wd[7:0];

	always_comb begin
		n = s_r;
		ld = 1'b0;
		mwe = 1'b0;
		if (s_r.tmr != '0) begin
			n.tmr = s_r.tmr - 1'b1;
		end
		// write channel: address and data in either order
		if (s_r.awr && s_axi_awvalid) begin
			n.aw_h = 1'b1;
			n.awa = s_axi_awaddr;
		end
		if (s_r.wr && s_axi_wvalid) begin
			n.w_h = 1'b1;
			n.wd = s_axi_wdata;
		end
		if (s_r.bv && s_axi_bready) begin
			n.bv = 1'b0;
		end
		if (s_r.aw_h && s_r.w_h && !s_r.bv) begin
			n.aw_h = 1'b0;
			n.w_h = 1'b0;
			n.bv = 1'b1;
			n.br = RESP_OKAY;
			unique case (s_r.awa)
				REG_CTRL: begin
					if (s_r.st != ST_IDLE) begin
						n.err = 1'b1;
					end else if (!(is_wr(op_w) || op_w == OP_ID4 || op_w == OP_PDR
							|| op_w == OP_SUSP || op_w == OP_RES)) begin
						n.err = 1'b1;
					end else if (op_w == OP_QPP && !s_r.cfg_quad) begin
						n.err = 1'b1;
					end else if (op_w == OP_CE && s_r.susp) begin
						n.err = 1'b1;
					end else if (op_w == OP_SUSP && (s_r.susp || s_r.tmr != '0)) begin
						n.err = 1'b1;
					end else if (is_prog(op_w) && s_r.nbuf == '0) begin
						n.err = 1'b1;
					end else begin
						n.op = op_w;
						n.st = is_wr(op_w) ? ST_UNLOCK : ST_CMD;
						n.ce_n = 1'b0;
						n.nb = '0;
						n.rd = RST_WORD;
						n.done = 1'b0;
						ld = 1'b1;
						if (op_w == OP_SUSP) begin
							n.susp = 1'b1;
							n.tmr = TMR_W'(SUSP_GAP);
						end
						if (op_w == OP_RES) begin
							n.susp = 1'b0;
						end
					end
				end
				REG_ADDR: begin
					n.adr = s_r.wd[23:0];
					n.nbuf = '0;
				end
				REG_DATA: begin
					if (s_r.st == ST_IDLE && s_r.nbuf < 9'(PAGE_BYTES)) begin
						mwe = 1'b1;
						n.nbuf = s_r.nbuf + 1'b1;
					end else begin
						n.err = 1'b1;
					end
				end
				REG_STAT: begin
					if (s_r.wd[1]) begin
						n.done = 1'b0;
					end
					if (s_r.wd[2]) begin
						n.err = 1'b0;
					end
				end
				REG_CFG: begin
					n.cfg_quad = s_r.wd[0];
				end
				default: begin
					n.br = RESP_SLVERR;
				end
			endcase
		end
		n.awr = !n.aw_h && !n.bv;
		n.wr = !n.w_h && !n.bv;
		// read channel
		if (s_r.rv && s_axi_rready) begin
			n.rv = 1'b0;
			n.arr = 1'b1;
		end else if (s_r.arr && s_axi_arvalid) begin
			n.arr = 1'b0;
			n.rv = 1'b1;
			n.rr = RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL: n.rdat = {24'h000000, s_r.op};
				REG_ADDR: n.rdat = {8'h00, s_r.adr};
				REG_DATA: n.rdat = {23'h000000, s_r.nbuf};
				REG_STAT: n.rdat = {27'h0000000, s_r.tmr != '0, s_r.susp, s_r.err,
					s_r.done, s_r.st != ST_IDLE};
				REG_RDAT: n.rdat = s_r.rd;
				REG_CFG: n.rdat = {31'h00000000, s_r.cfg_quad};
				default: begin
					n.rdat = RST_WORD;
					n.rr = RESP_SLVERR;
				end
			endcase
		end
		// ************************************************************
		// link engine
		// ************************************************************
		if (s_r.st == ST_GAP || s_r.st == ST_END) begin
			if (s_r.div == 8'(2 * SCK_HALF - 1)) begin
				n.div = '0;
				if (s_r.st == ST_GAP) begin
					n.st = ST_CMD;
					n.ce_n = 1'b0;
					ld = 1'b1;
				end else begin
					n.st = ST_IDLE;
					n.done = 1'b1;
				end
			end else begin
				n.div = s_r.div + 1'b1;
			end
		end else if (s_r.st != ST_IDLE) begin
			if (s_r.div == 8'(SCK_HALF - 1)) begin
				n.div = '0;
				n.sck = !s_r.sck;
				if (!s_r.sck) begin
					if (s_r.st == ST_RDAT) begin
						n.sh = s_r.q ? {s_r.sh[27:0], in_s} : {s_r.sh[30:0], in_s[1]};
					end
				end else begin
					n.cnt = s_r.cnt - 1'b1;
					if (s_r.cnt == 6'h01) begin
						ld = 1'b1;
						unique case (s_r.st)
							ST_UNLOCK: begin
								n.st = ST_GAP;
								n.ce_n = 1'b1;
							end
							ST_CMD: begin
								if (s_r.op == OP_PDR || s_r.op == OP_SE || s_r.op == OP_BE
										|| is_prog(s_r.op)) begin
									n.st = ST_ADR;
								end else if (s_r.op == OP_ID4) begin
									n.st = ST_DUM;
								end else begin
									n.st = ST_END;
								end
							end
							ST_ADR: begin
								if (s_r.op == OP_PDR) begin
									n.st = ST_DUM;
								end else if (is_prog(s_r.op)) begin
									n.st = ST_WDAT;
								end else begin
									n.st = ST_END;
								end
							end
							ST_DUM: n.st = ST_RDAT;
							ST_WDAT: n.st = (s_r.nb == s_r.nbuf) ? ST_END : ST_WDAT;
							ST_RDAT: begin
								n.rd = {s_r.rd[23:0], s_r.sh[7:0]};
								n.nb = s_r.nb + 1'b1;
								n.st = (n.nb == (s_r.op == OP_ID4 ? ID_BYTES : PD_BYTES))
									? ST_END : ST_RDAT;
							end
							default: n.st = ST_END;
						endcase
						if (n.st == ST_END) begin
							n.ce_n = 1'b1;
						end
					end else if (s_r.st != ST_RDAT) begin
						n.sh = s_r.q ? {s_r.sh[27:0], 4'h0} : {s_r.sh[30:0], 1'b0};
					end
				end
			end else begin
				n.div = s_r.div + 1'b1;
			end
		end
		// phase load: shift word, lane width and clock count
		if (ld) begin
			n.div = '0;
			unique case (n.st)
				ST_UNLOCK: begin
					n.sh = {OP_UNLOCK, 24'h000000};
					n.q = 1'b0;
					n.cnt = CLK_CMD1;
				end
				ST_CMD: begin
					n.sh = {n.op, 24'h000000};
					n.q = n.op == OP_ID4;
					n.cnt = n.q ? CLK_CMD4 : CLK_CMD1;
				end
				ST_ADR: begin
					if (n.op == OP_SE) begin
						n.sh = {n.adr[23:12], 20'h00000};
					end else if (n.op == OP_BE) begin
						n.sh = {n.adr[23:13], 21'h000000};
					end else begin
						n.sh = {n.adr, 8'h00};
					end
					n.q = n.op == OP_QPP;
					n.cnt = n.q ? CLK_ADR4 : CLK_ADR1;
				end
				ST_DUM: begin
					n.sh = RST_WORD;
					n.q = n.op == OP_ID4;
					n.cnt = n.q ? CLK_DUM_ID : CLK_DUM_PD;
				end
				ST_WDAT: begin
					n.sh = {buf_rd, 24'h000000};
					n.q = n.op == OP_QPP;
					n.cnt = n.q ? CLK_BYTE4 : CLK_BYTE1;
					n.nb = n.nb + 1'b1;
				end
				ST_RDAT: begin
					n.cnt = n.q ? CLK_BYTE4 : CLK_BYTE1;
				end
				default: begin
				end
			endcase
		end
		n.io = n.q ? n.sh[31:28] : {3'h0, n.sh[31]};
		if (n.st == ST_UNLOCK || n.st == ST_CMD || n.st == ST_ADR || n.st == ST_WDAT) begin
			n.oe = n.q ? 4'hF : 4'h1;
		end else begin
			n.oe = 4'h0;
		end
	end

	localparam fsh_state_t S_RST = '{st: ST_IDLE, ce_n: 1'b1, awr: 1'b1, wr: 1'b1,
		arr: 1'b1, default: '0};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= S_RST;
		end else begin
			s_r <= n;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign s_axi_awready = s_r.awr;
	assign s_axi_wready = s_r.wr;
	assign s_axi_bresp = s_r.br;
	assign s_axi_bvalid = s_r.bv;
	assign s_axi_arready = s_r.arr;
	assign s_axi_rdata = s_r.rdat;
	assign s_axi_rresp = s_r.rr;
	assign s_axi_rvalid = s_r.rv;
	assign flash_ce_n = s_r.ce_n;
	assign flash_sck = s_r.sck;
	assign flash_io_o = s_r.io;
	assign flash_io_oe = s_r.oe;

	// ************************************************************
	// checks
	// ************************************************************
	a_ce_idle_high:
	assert property (@(posedge clk) disable iff (rst)
		(s_r.st == ST_IDLE || s_r.st == ST_GAP) |-> s_r.ce_n && !s_r.sck)
		else $error("chip enable low outside a frame");

	a_cmd_clock_count:
	assert property (@(posedge clk) disable iff (rst)
		(s_r.st == ST_CMD && $past(s_r.st) != ST_CMD)
		|-> s_r.cnt == (s_r.op == OP_ID4 ? CLK_CMD4 : CLK_CMD1))
		else $error("command phase has wrong clock count");

	a_unlock_first:
	assert property (@(posedge clk) disable iff (rst)
		(s_r.st == ST_CMD && $past(s_r.st) != ST_CMD && is_wr(s_r.op))
		|-> $past(s_r.st) == ST_GAP)
		else $error("erase or program without unlock frame");

	a_quad_needs_cfg:
	assert property (@(posedge clk) disable iff (rst)
		($past(s_r.st) == ST_IDLE && s_r.st == ST_UNLOCK && s_r.op == OP_QPP)
		|-> $past(s_r.cfg_quad))
		else $error("quad program started without config bit");

	a_susp_spacing:
	assert property (@(posedge clk) disable iff (rst)
		($past(s_r.st) == ST_IDLE && s_r.st == ST_CMD && s_r.op == OP_SUSP)
		|-> $past(s_r.tmr) == '0 && s_r.tmr == TMR_W'(SUSP_GAP))
		else $error("suspend issued too soon");

	a_no_chip_susp:
	assert property (@(posedge clk) disable iff (rst)
		($past(s_r.st) == ST_IDLE && s_r.st == ST_UNLOCK && s_r.op == OP_CE)
		|-> !$past(s_r.susp))
		else $error("chip erase issued while suspended");

	a_page_bytes:
	assert property (@(posedge clk) disable iff (rst)
		(s_r.st == ST_WDAT) |-> s_r.nb != '0 && s_r.nb <= s_r.nbuf && s_r.nbuf <= 9'(PAGE_BYTES))
		else $error("program data count out of range");

	a_read_released:
	assert property (@(posedge clk) disable iff (rst)
		(s_r.st == ST_RDAT || s_r.st == ST_DUM) |-> s_r.oe == 4'h0 && !s_r.ce_n)
		else $error("host drives lanes while flash answers");

	a_id_three_bytes:
	assert property (@(posedge clk) disable iff (rst)
		($past(s_r.st) == ST_RDAT && s_r.st == ST_END && s_r.op == OP_ID4)
		|-> s_r.nb == ID_BYTES ##1 s_r.ce_n)
		else $error("id read ended after wrong byte count");
endmodule
`default_nettype wire

// ===== core/fsh_pkg.sv
/*
 * shared constants for the serial flash host controller: register map,
 * flash command codes, link clock counts and frame states.
 * assumes a 200 MHz system clock and one aligned 32-bit word per register.
 */
package fsh_pkg;
	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_MHZ = 200;
	localparam int T_SUSP_GAP_US = 500;
	localparam int SUSP_GAP_CYC = T_SUSP_GAP_US * CLK_MHZ;
	localparam int TMR_W = 17;
	localparam int SCK_HALF_CYC = 4;
	localparam int PAGE_BYTES = 256;

	// ************************************************************
	// register offsets and responses
	// ************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_RDAT = 8'h10;
	localparam logic [7:0] REG_CFG = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] RST_WORD = 32'h00000000;

	// ************************************************************
	// flash commands
	// ************************************************************
	localparam logic [7:0] OP_ID4 = 8'hAF;
	localparam logic [7:0] OP_PDR = 8'h5A;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE = 8'hD8;
	localparam logic [7:0] OP_CE = 8'hC7;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_QPP = 8'h32;
	localparam logic [7:0] OP_SUSP = 8'hB0;
	localparam logic [7:0] OP_RES = 8'h30;
	localparam logic [7:0] OP_UNLOCK = 8'h06;

	// ************************************************************
	// link clocks per phase and byte counts
	// ************************************************************
	localparam logic [5:0] CLK_CMD1 = 6'h08;
	localparam logic [5:0] CLK_CMD4 = 6'h02;
	localparam logic [5:0] CLK_ADR1 = 6'h18;
	localparam logic [5:0] CLK_ADR4 = 6'h06;
	localparam logic [5:0] CLK_DUM_ID = 6'h02;
	localparam logic [5:0] CLK_DUM_PD = 6'h08;
	localparam logic [5:0] CLK_BYTE1 = 6'h08;
	localparam logic [5:0] CLK_BYTE4 = 6'h02;
	localparam logic [8:0] ID_BYTES = 9'h003;
	localparam logic [8:0] PD_BYTES = 9'h004;

	typedef enum logic [3:0] {
		ST_IDLE, ST_UNLOCK, ST_GAP, ST_CMD, ST_ADR, ST_DUM, ST_WDAT, ST_RDAT, ST_END
	} fsh_st_t;
endpackage

// ===== core/fsh_sync.sv
/*
 * two flip-flop synchroniser for the flash data lanes.
 * assumes inputs are asynchronous to clk; only the second stage is read.
 */
`timescale 1ns/10ps
`default_nettype none
module fsh_sync #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} fsh_sync_t;

	fsh_sync_t s_r;
	fsh_sync_t s_nxt;

	always_comb begin
		s_nxt.meta = d;
		s_nxt.q = s_r.meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.q;
endmodule
`default_nettype wire

// ===== core/fsh_pbuf.sv
/*
 * page buffer: one write port, one read port with registered read data.
 * assumes the reader holds its address for a cycle before using the data.
 */
`timescale 1ns/10ps
`default_nettype none
module fsh_pbuf #(
	parameter int DW = 8,
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// read port
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];
	logic [DW-1:0] rdata_r;

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_r <= mem[raddr];
	end

	assign rdata = rdata_r;
endmodule
`default_nettype wire

// ===== tb/fsh_flash_model.sv
/*
 * behavioural flash device for the host bench: decodes frames, answers id and parameter reads.
 * assumes all lanes are pulled up when nobody drives them; sck idles low.
 */
`timescale 1ns/10ps
`default_nettype none
module fsh_flash_model
	import fsh_pkg::*;
#(
	// arbitrary id bytes and parameter word
	parameter logic [23:0] ID_WORD = 24'h5C3D7E,
	parameter logic [31:0] PARAM_WORD = 32'hA5C3961E
) (
	// link
	input wire logic ce_n,
	input wire logic sck,
	input wire logic [3:0] io,
	// drive back
	output logic [3:0] q_o,
	output logic [3:0] q_oe
);
	int n = 0;
	int nb = 0;
	int rejects = 0;
	logic [7:0] op = 8'h00;
	logic [7:0] qs;
	logic [7:0] lastb;
	logic [7:0] last_op = 8'h00;
	logic [31:0] sh;
	logic [23:0] adr;
	logic wel = 1'b0;
	logic susp = 1'b0;
	int dirty = 0;
	logic [7:0] mem [4096];
	logic [4095:0] used = '0;
	// store a programmed byte inside its page, count a location programmed twice
	task automatic put(input logic [7:0] b);
		logic [11:0] a;
		a = {adr[11:8], adr[7:0] + 8'(nb - 1)};
		if (used[a])
			dirty++;
		used[a] = 1'b1;
		mem[a] = b;
	endtask
	initial begin
		q_o = 4'h0;
		q_oe = 4'h0;
	end
	// ************************************************************
	// frame decode
	// ************************************************************
	always @(negedge ce_n) begin
		n = 0;
		nb = 0;
		op = 8'h00;
	end
	always @(posedge sck) begin
		if (!ce_n) begin
			n++;
			qs = {qs[3:0], io};
			if (n == 2 && qs == OP_ID4) begin
				op = OP_ID4;
			end else if (op == OP_QPP && n > 8) begin
				sh = {sh[27:0], io};
				if (n == 14)
					adr = sh[23:0];
				if (n > 14 && n % 2 == 0) begin
					nb++;
					lastb = sh[7:0];
					put(lastb);
				end
			end else if (op != OP_ID4) begin
				sh = {sh[30:0], io[0]};
				if (n == 8)
					op = sh[7:0];
				if (n == 32)
					adr = sh[23:0];
				// only whole bytes count, a partial byte is dropped
				if (op == OP_PP && n > 32 && n % 8 == 0) begin
					nb++;
					lastb = sh[7:0];
					put(lastb);
				end
			end
		end
	end
	// ************************************************************
	// read answers, streamed until ce_n rises
	// ************************************************************
	always @(negedge sck) begin
		if (!ce_n && op == OP_ID4 && n >= 4) begin
			q_oe = 4'hF;
			q_o = ID_WORD[23 - 4 * ((n - 4) % 6) -: 4];
		end else if (!ce_n && op == OP_PDR && n >= 40) begin
			q_oe = 4'h2;
			q_o = {2'b00, PARAM_WORD[31 - (n - 40) % 32], 1'b0};
		end
	end
	always @(posedge ce_n) begin
		q_oe = 4'h0;
		last_op = op;
		if (op == OP_UNLOCK)
			wel = 1'b1;
		if (op == OP_SUSP)
			susp = 1'b1;
		if (op == OP_RES)
			susp = 1'b0;
		if (op inside {OP_SE, OP_BE, OP_CE, OP_PP, OP_QPP}) begin
			if (!wel || (op == OP_CE && susp))
				rejects++;
			else if (!(op inside {OP_PP, OP_QPP}))
				used = '0;
			wel = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== tb/fsh_host_tb_top.sv
/*
 * self-checking bench for the flash host: axi4-lite orders, flash model on the lanes.
 * assumes the model sits behind pulled-up lanes and the suspend gap is shortened.
 */
`timescale 1ns/10ps
`default_nettype none
module fsh_host_tb_top
	import fsh_pkg::*;
;
	// arbitrary id bytes and parameter word
	localparam logic [23:0] ID_WORD = 24'h5C3D7E;
	localparam logic [31:0] PARAM_WORD = 32'hA5C3961E;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, ce_n, sck;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic [3:0] io_o, io_oe, q_o, q_oe, io_w;
	int mismatches = 0;
	int cmp_count = 0;
	int cycles = 0;
	assign io_w = (io_oe & io_o) | (~io_oe & q_oe & q_o) | (~io_oe & ~q_oe);
	fsh_host #(.SUSP_GAP(50), .SCK_HALF(4)) i_fsh_host (.clk(clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.flash_ce_n(ce_n), .flash_sck(sck), .flash_io_o(io_o), .flash_io_oe(io_oe),
		.flash_io_i(io_w));
	fsh_flash_model #(.ID_WORD(ID_WORD), .PARAM_WORD(PARAM_WORD)) i_fsh_flash_model (
		.ce_n(ce_n), .sck(sck), .io(io_w), .q_o(q_o), .q_oe(q_oe));
	// ************************************************************
	// bus and check tasks
	// ************************************************************
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(negedge clk);
			ta = pa & awready;
			tw = pw & wready;
			@(posedge clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			pa = pa & ~ta;
			pw = pw & ~tw;
		end
		do @(negedge clk); while (bvalid !== 1'b1);
		rs = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic op(input logic [7:0] c, input logic e);
		int k;
		k = 0;
		axw(REG_CTRL, {24'h0, c});
		do begin
			axr(REG_STAT);
			k++;
		end while (rd[0] !== 1'b0 && k < 4000);
		chk("err", {31'h0, e}, {31'h0, rd[2]});
		axw(REG_STAT, 32'h6);
	endtask
	task automatic load(input logic [23:0] a, input int cnt);
		axw(REG_ADDR, {8'h00, a});
		for (int i = 0; i < cnt; i++)
			axw(REG_DATA, 32'h40 + 32'(i));
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		axr(REG_STAT);
		chk("stat", RST_WORD, rd);
		axr(REG_CFG);
		chk("cfg", RST_WORD, rd);
		axr(8'h40);
		chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		axw(8'h44, 32'h1);
		chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		$display("test reset done");
	endtask
	task automatic t_reads;
		op(OP_ID4, 1'b0);
		axr(REG_RDAT);
		chk("id", {8'h00, ID_WORD}, rd);
		axw(REG_ADDR, 32'h00ABCDEF);
		op(OP_PDR, 1'b0);
		axr(REG_RDAT);
		chk("param", PARAM_WORD, rd);
		chk("paddr", 32'h00ABCDEF, {8'h00, i_fsh_flash_model.adr});
		$display("test reads done");
	endtask
	task automatic t_erase;
		axw(REG_ADDR, 32'h00123456);
		op(OP_SE, 1'b0);
		chk("se", 32'h00123000, {8'h00, i_fsh_flash_model.adr});
		axw(REG_ADDR, 32'h0012FFFF);
		op(OP_BE, 1'b0);
		chk("be", 32'h0012E000, {8'h00, i_fsh_flash_model.adr});
		op(OP_CE, 1'b0);
		chk("ce", {24'h0, OP_CE}, {24'h0, i_fsh_flash_model.last_op});
		chk("ce clocks", 32'h8, 32'(i_fsh_flash_model.n));
		chk("unlock", 32'h0, 32'(i_fsh_flash_model.rejects));
		$display("test erase done");
	endtask
	task automatic t_prog;
		load(24'h0400F0, 0);
		op(OP_PP, 1'b1);
		load(24'h0400FE, 3);
		axr(REG_DATA);
		chk("count", 32'h3, rd);
		op(OP_PP, 1'b0);
		chk("pp bytes", 32'h3, 32'(i_fsh_flash_model.nb));
		chk("pp last", 32'h42, {24'h0, i_fsh_flash_model.lastb});
		chk("pp wrap", 32'h42, {24'h0, i_fsh_flash_model.mem[0]});
		load(24'h055A10, 2);
		op(OP_QPP, 1'b1);
		axw(REG_CFG, 32'h1);
		load(24'h055A10, 2);
		op(OP_QPP, 1'b0);
		chk("qpp addr", 32'h00055A10, {8'h00, i_fsh_flash_model.adr});
		chk("qpp bytes", 32'h2, 32'(i_fsh_flash_model.nb));
		chk("qpp last", 32'h41, {24'h0, i_fsh_flash_model.lastb});
		chk("qpp data", 32'h41, {24'h0, i_fsh_flash_model.mem[12'hA11]});
		chk("erased", 32'h0, 32'(i_fsh_flash_model.dirty));
		$display("test program done");
	endtask
	task automatic t_susp;
		op(OP_SUSP, 1'b0);
		axr(REG_STAT);
		chk("suspended", 32'h1, {31'h0, rd[3]});
		op(OP_SUSP, 1'b1);
		op(OP_CE, 1'b1);
		op(OP_RES, 1'b0);
		axr(REG_STAT);
		chk("resumed", 32'h0, {31'h0, rd[3]});
		chk("rejects", 32'h0, 32'(i_fsh_flash_model.rejects));
		$display("test suspend done");
	endtask
	// ************************************************************
	// clock, timeout and main sequence
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			close_out();
		end
	end
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_reads();
		t_erase();
		t_prog();
		t_susp();
		close_out();
	end
endmodule
`default_nettype wire
